// [hlt_timer_defs.svh]
/*
  Register offsets, field positions, reset values and mode codes for the
  hardware limit timer. Assumes a 32-bit classic Wishbone register bus.
*/
`ifndef HLT_TIMER_DEFS_SVH
`define HLT_TIMER_DEFS_SVH

// Register byte offsets (one aligned word each)
`define OFS_TIMER_CONTROL      6'h00
`define OFS_HW_LIMIT_CONTROL   6'h04
`define OFS_TIMER_CLOCK_SELECT 6'h08
`define OFS_EXT_RESET_SELECT   6'h0C
`define OFS_PERIOD_VALUE       6'h10
`define OFS_COUNT_VALUE        6'h14
`define OFS_PULSE_WIDTH        6'h18
`define OFS_STATUS             6'h1C

// Field positions
`define BIT_RUN                7
`define BIT_PRESCALER_SYNC     7

// Reset values
`define RST_PERIOD             8'hFF
`define RST_COUNT              8'h00

// Mode codes
`define MODE_LVL_RST_LOW       5'h06
`define MODE_LVL_RST_HIGH      5'h07
`define MODE_ONE_SHOT          5'h08
`define MODE_EDGE_OS_RISE      5'h09
`define MODE_EDGE_OS_FALL      5'h0A
`define MODE_EDGE_OS_BOTH      5'h0B
`define MODE_HL_OS_RISE        5'h0C
`define MODE_HL_OS_FALL        5'h0D
`define MODE_LVL_OS_HIGH       5'h0E
`define MODE_LVL_OS_LOW        5'h0F

// Resume delay after a limit reset edge, in clocks
`define RESUME_CYCLES          2'h2

`endif

// [hlt_timer_pkg.sv]
/*
  Types for the hardware limit timer.
  Assumes hlt_timer_defs.svh supplies the numbers.
*/
package hlt_timer_pkg;
  // One-shot sequencing states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,   // Waiting for run or start edge
    ST_COUNT = 3'b010,   // Counting
    ST_HOLD  = 3'b100    // Held after limit reset
  } seq_e;
endpackage

// [hlt_timer.sv]
/*
  Hardware limit timer: 8-bit count, period match, one-shot and hardware
  limit modes, pulse drive for a paired PWM unit, sleep behaviour.
  Assumes a classic Wishbone master on CLK, and external reset candidates
  that are asynchronous to CLK.
*/
// The implementer's own choices: the address map and the Wishbone interface to the registers.
// Operation
// - Level limit mode holds count in reset
// - Run bit clear ignores external reset
// - Reset or period match drives PWM high
// - One-shot period match resets, clears run
// - One-shot PWM runs from set to match
// - New one-shot cycle only after match
// - Edge one-shot starts on selected edge
// - Halted edge one-shot needs fresh edge
// - Edge one-shot PWM from edge to match
// - Limit one-shot: first edge starts, later reset
// - Resume counting two clocks after reset edge
// - Edges ignored until run bit set
// - Every start/reset edge activates PWM drive
// - Level one-shot holds reset while level present
// - Level one-shot match clears run, needs edge
// - Level one-shot PWM from start edge
// - Sync bit one stops timer in sleep
// - Sync bit zero keeps counting in sleep
// - Period match returns count to zero
// - Source selector picks external reset input
`timescale 1ns/10ps
`include "hlt_timer_defs.svh"

module hlt_timer
(
  input  wire logic        CLK,
  input  wire logic        RESET,
  input  wire logic [5:0]  ADR_I,
  input  wire logic [31:0] DAT_I,
  output logic      [31:0] DAT_O,
  input  wire logic        WE_I,
  input  wire logic [3:0]  SEL_I,
  input  wire logic        CYC_I,
  input  wire logic        STB_I,
  output logic             ACK_O,
  input  wire logic [15:0] RESET_SOURCES,
  input  wire logic        SLEEP,
  output logic      [7:0]  COUNT_OUT,
  output logic             PERIOD_MATCH,
  output logic             PWM_DRIVE,
  output logic             OSC_KEEP
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [7:0]  control_q;      // Run, prescale, postscale
  logic [7:0]  hlt_q;          // Sync, polarity, mode
  logic [7:0]  clksel_q;       // Clock source select
  logic [3:0]  rsel_q;         // Reset source select
  logic [7:0]  period_q;       // Period register
  logic [7:0]  count_q;        // Count register
  logic [7:0]  width_q;        // Pulse width register
  logic        ack_q;          // Bus acknowledge
  logic [2:0]  ers_sync_q;     // Three-stage synchroniser
  logic        ers_q;          // Filtered external level
  logic        ers_prev_q;     // Previous filtered level
  logic        pwm_q;          // PWM drive
  logic        match_q;        // Match seen, clear next cycle
  logic [1:0]  hold_q;         // Resume delay counter
  hlt_timer_pkg::seq_e state_q;// One-shot sequencer
  logic [4:0]  mode;           // Mode field
  logic        run;            // Run bit
  logic        ers_raw;        // Selected source
  logic        rise;           // Rising edge of filtered level
  logic        fall;           // Falling edge of filtered level
  logic        sel_edge;       // Edge selected by mode
  logic        lvl_reset;      // Level reset asserted
  logic        is_match;       // Count equals period
  logic        active;         // Timer allowed to advance
  logic        wr;             // Bus write strobe
  logic        rd_unused;      // Unused bus bits
  logic        sw_run_clr;     // Hardware clears run bit
  logic        counting;       // Count advances this cycle
  logic        cnt_reset;      // Count forced to zero

  assign mode      = hlt_q[4:0];
  assign run       = control_q[`BIT_RUN];
  assign wr        = CYC_I && STB_I && WE_I && !ack_q && SEL_I[0];
  assign rd_unused = ^DAT_I[31:8] ^ ^SEL_I[3:1];

  ////////////////////////////////////////////////////////////////////////
  // Helper functions

  // Mode belongs to the one-shot family
  function automatic logic one_shot(input logic [4:0] m);
    one_shot = m[3];
  endfunction

  // Active reset level for level modes
  function automatic logic lvl_active(input logic [4:0] m, input logic l);
    case (m)
      `MODE_LVL_RST_LOW:  lvl_active = !l;
      `MODE_LVL_RST_HIGH: lvl_active = l;
      `MODE_LVL_OS_HIGH:  lvl_active = l;
      `MODE_LVL_OS_LOW:   lvl_active = !l;
      default:            lvl_active = 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // External reset selection and synchroniser

  // Source selector; 0000 is the input pin
  assign ers_raw = RESET_SOURCES[rsel_q];

  // Three flops; a change counts when stages two and three agree
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      ers_sync_q <= 3'h0;
      ers_q      <= 1'b0;
      ers_prev_q <= 1'b0;
    end
    else
    begin
      ers_sync_q <= {ers_sync_q[1:0], ers_raw};
      if (ers_sync_q[1] == ers_sync_q[2])
      begin
        ers_q <= ers_sync_q[2];
      end
      ers_prev_q <= ers_q;
    end
  end

  assign rise = ers_q && !ers_prev_q;
  assign fall = !ers_q && ers_prev_q;

  // Edge chosen by mode
  always_comb
  begin
    case (mode)
      `MODE_EDGE_OS_RISE: sel_edge = rise;
      `MODE_EDGE_OS_FALL: sel_edge = fall;
      `MODE_EDGE_OS_BOTH: sel_edge = rise | fall;
      `MODE_HL_OS_RISE:   sel_edge = rise;
      `MODE_HL_OS_FALL:   sel_edge = fall;
      `MODE_LVL_OS_HIGH:  sel_edge = fall;
      `MODE_LVL_OS_LOW:   sel_edge = rise;
      default:            sel_edge = 1'b0;
    endcase
  end

  // Level reset only honoured while running
  assign lvl_reset = run && lvl_active(mode, ers_q);

  ////////////////////////////////////////////////////////////////////////
  // Sleep gating and match

  // Sync bit set stops the timer in sleep, else it keeps counting
  assign active   = !(SLEEP && hlt_q[`BIT_PRESCALER_SYNC]);
  assign OSC_KEEP = SLEEP && !hlt_q[`BIT_PRESCALER_SYNC] && (clksel_q[2:0] != 3'h0);
  assign is_match = (count_q == period_q);

  // Sequencer decides when counting happens in one-shot modes other than MODE_ONE_SHOT
  always_comb
  begin
    counting = 1'b0;
    if (!one_shot(mode))
    begin
      counting = run && !lvl_reset;
    end
    else
    begin
      case (mode)
        `MODE_ONE_SHOT: counting = run;
        default:        counting = run && (state_q == hlt_timer_pkg::ST_COUNT)
                                   && !lvl_reset;
      endcase
    end
  end

  // Match clears the count on the very next edge, never period plus one
  assign cnt_reset  = lvl_reset || (counting && is_match);
  assign sw_run_clr = active && counting && is_match && one_shot(mode);

  ////////////////////////////////////////////////////////////////////////
  // One-shot sequencer

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      state_q <= hlt_timer_pkg::ST_IDLE;
      hold_q  <= 2'h0;
    end
    else if (!run || !active)
    begin
      // Halted: a fresh edge is needed after run is set again
      if (!run)
      begin
        state_q <= hlt_timer_pkg::ST_IDLE;
      end
    end
    else
    begin
      case (state_q)
        hlt_timer_pkg::ST_IDLE:
        begin
          if (sel_edge)
          begin
            state_q <= hlt_timer_pkg::ST_COUNT;
          end
        end
        hlt_timer_pkg::ST_COUNT:
        begin
          // Later edge in limit one-shot resets and holds
          if (sel_edge && (mode == `MODE_HL_OS_RISE || mode == `MODE_HL_OS_FALL))
          begin
            state_q <= hlt_timer_pkg::ST_HOLD;
            hold_q  <= `RESUME_CYCLES - 2'h1;
          end
        end
        hlt_timer_pkg::ST_HOLD:
        begin
          if (hold_q == 2'h0)
          begin
            state_q <= hlt_timer_pkg::ST_COUNT;
          end
          else
          begin
            hold_q <= hold_q - 2'h1;
          end
        end
        default:
        begin
          state_q <= hlt_timer_pkg::ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Count register

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      count_q <= `RST_COUNT;
      match_q <= 1'b0;
    end
    else if (wr && ADR_I == `OFS_COUNT_VALUE)
    begin
      count_q <= DAT_I[7:0];
      match_q <= 1'b0;
    end
    else if (active)
    begin
      match_q <= counting && is_match;
      if (cnt_reset || state_q == hlt_timer_pkg::ST_HOLD)
      begin
        count_q <= 8'h00;
      end
      else if (counting)
      begin
        count_q <= count_q + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // PWM drive

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      pwm_q <= 1'b0;
    end
    else if (!one_shot(mode))
    begin
      // Level limit: reset or period match raises drive
      if (lvl_reset || match_q)
      begin
        pwm_q <= 1'b1;
      end
      else if (run && count_q == width_q)
      begin
        pwm_q <= 1'b0;
      end
    end
    else if (mode == `MODE_ONE_SHOT)
    begin
      // Starts with run, ends at width; cleared run extends it
      if (run && !pwm_q && count_q == 8'h00 && !match_q)
      begin
        pwm_q <= 1'b1;
      end
      else if (run && count_q == width_q)
      begin
        pwm_q <= 1'b0;
      end
    end
    else
    begin
      // Start edge and later limit edges raise drive, match does not
      if (run && sel_edge && state_q != hlt_timer_pkg::ST_HOLD &&
          (state_q == hlt_timer_pkg::ST_IDLE ||
           mode == `MODE_HL_OS_RISE || mode == `MODE_HL_OS_FALL))
      begin
        pwm_q <= 1'b1;
      end
      else if (counting && count_q == width_q)
      begin
        pwm_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register writes

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      control_q <= 8'h00;
      hlt_q     <= 8'h00;
      clksel_q  <= 8'h00;
      rsel_q    <= 4'h0;
      period_q  <= `RST_PERIOD;
      width_q   <= 8'h00;
    end
    else
    begin
      if (wr && ADR_I == `OFS_TIMER_CONTROL)
      begin
        control_q <= DAT_I[7:0];
      end
      else if (sw_run_clr)
      begin
        control_q[`BIT_RUN] <= 1'b0;
      end
      if (wr && ADR_I == `OFS_HW_LIMIT_CONTROL)
      begin
        hlt_q <= DAT_I[7:0];
      end
      if (wr && ADR_I == `OFS_TIMER_CLOCK_SELECT)
      begin
        clksel_q <= {4'h0, DAT_I[3:0]};
      end
      if (wr && ADR_I == `OFS_EXT_RESET_SELECT)
      begin
        rsel_q <= DAT_I[3:0];
      end
      if (wr && ADR_I == `OFS_PERIOD_VALUE)
      begin
        period_q <= DAT_I[7:0];
      end
      if (wr && ADR_I == `OFS_PULSE_WIDTH)
      begin
        width_q <= DAT_I[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus acknowledge and read data

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      ack_q <= 1'b0;
      DAT_O <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= CYC_I && STB_I && !ack_q;
      case (ADR_I)
        `OFS_TIMER_CONTROL:      DAT_O <= {24'h0, control_q};
        `OFS_HW_LIMIT_CONTROL:   DAT_O <= {24'h0, hlt_q};
        `OFS_TIMER_CLOCK_SELECT: DAT_O <= {24'h0, clksel_q};
        `OFS_EXT_RESET_SELECT:   DAT_O <= {28'h0, rsel_q};
        `OFS_PERIOD_VALUE:       DAT_O <= {24'h0, period_q};
        `OFS_COUNT_VALUE:        DAT_O <= {24'h0, count_q};
        `OFS_PULSE_WIDTH:        DAT_O <= {24'h0, width_q};
        `OFS_STATUS:             DAT_O <= {27'h0, rd_unused & 1'b0, ers_q, state_q};
        default:                 DAT_O <= 32'h0000_0000;
      endcase
    end
  end

  assign ACK_O        = ack_q;
  assign COUNT_OUT    = count_q;
  assign PERIOD_MATCH = match_q;
  assign PWM_DRIVE    = pwm_q;

endmodule

// [hlt_timer_chk.sv]
/*
  Port checker for the limit timer.
  Assumes the bind at the foot and the map of hlt_timer_defs.svh.
*/
`timescale 1ns/10ps
`include "hlt_timer_defs.svh"
module hlt_timer_chk
(
  input wire logic        CLK,
  input wire logic        RESET,
  input wire logic [5:0]  ADR_I,
  input wire logic [31:0] DAT_I,
  input wire logic        WE_I,
  input wire logic [3:0]  SEL_I,
  input wire logic        CYC_I,
  input wire logic        STB_I,
  input wire logic        ACK_O,
  input wire logic [15:0] RESET_SOURCES,
  input wire logic        SLEEP,
  input wire logic [7:0]  COUNT_OUT,
  input wire logic        PERIOD_MATCH,
  input wire logic        PWM_DRIVE,
  input wire logic        OSC_KEEP
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  logic [4:0] mode_q; // Mirrored mode
  logic       sync_q; // Mirrored sync bit
  logic       run_q;  // Run bit as written
  logic [2:0] csel_q; // Mirrored clock select
  logic [3:0] rsel_q; // Mirrored source select
  logic [7:0] pw_q;   // Mirrored pulse width
  logic [2:0] low_q;  // Low cycles, saturating
  logic       wr;     // Write taken
  assign wr = CYC_I && STB_I && !ACK_O && WE_I && SEL_I[0];
  ////////////////////////////////////////////////////////////////////////////
  // Shadow of written fields
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      mode_q <= 5'h00;
      sync_q <= 1'h0;
      run_q  <= 1'h0;
      csel_q <= 3'h0;
      rsel_q <= 4'h0;
      pw_q   <= 8'h00;
    end
    else if (wr)
    begin
      if (ADR_I == `OFS_HW_LIMIT_CONTROL) mode_q <= DAT_I[4:0];
      if (ADR_I == `OFS_HW_LIMIT_CONTROL) sync_q <= DAT_I[7];
      if (ADR_I == `OFS_TIMER_CONTROL) run_q <= DAT_I[7];
      if (ADR_I == `OFS_TIMER_CLOCK_SELECT) csel_q <= DAT_I[2:0];
      if (ADR_I == `OFS_EXT_RESET_SELECT) rsel_q <= DAT_I[3:0];
      if (ADR_I == `OFS_PULSE_WIDTH) pw_q <= DAT_I[7:0];
    end
  end
  // Length of the selected source's low level
  always_ff @(posedge CLK)
  begin
    if (RESET || RESET_SOURCES[rsel_q])
      low_q <= 3'h0;
    else if (low_q != 3'h7)
      low_q <= low_q + 3'h1;
  end
  ////////////////////////////////////////////////////////////////////////////
  a_ack_pulse: assert property (ACK_O |=> !ACK_O)
    else $error("ack longer than one cycle");
  a_ack_answer: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
    else $error("request not answered next cycle");
  a_match_wrap: assert property (PERIOD_MATCH |-> COUNT_OUT == 8'h00)
    else $error("count not zero after period match");
  a_sleep_freeze: assert property (SLEEP && sync_q ##1 SLEEP && sync_q ##1 SLEEP && sync_q
    |-> $stable(COUNT_OUT))
    else $error("count moved in sleep");
  a_osc_keep: assert property (OSC_KEEP == (SLEEP && !sync_q && csel_q != 3'h0))
    else $error("oscillator keep wrong");
  a_level_hold: assert property (mode_q == `MODE_LVL_RST_LOW && run_q && low_q == 3'h7
    |=> COUNT_OUT == 8'h00)
    else $error("count not held by low level");
  a_oneshot_stop: assert property (mode_q[3] && PERIOD_MATCH |=> (COUNT_OUT == 8'h00) [*3])
    else $error("one-shot kept counting");
  a_pwm_on_match: assert property (mode_q[4:1] == 4'h3 && pw_q != 8'h00 && PERIOD_MATCH
    |-> ##[0:3] PWM_DRIVE)
    else $error("drive not raised at match");
endmodule
bind hlt_timer hlt_timer_chk i_chk (.CLK(CLK), .RESET(RESET), .ADR_I(ADR_I), .DAT_I(DAT_I),
  .WE_I(WE_I), .SEL_I(SEL_I), .CYC_I(CYC_I), .STB_I(STB_I), .ACK_O(ACK_O),
  .RESET_SOURCES(RESET_SOURCES), .SLEEP(SLEEP), .COUNT_OUT(COUNT_OUT),
  .PERIOD_MATCH(PERIOD_MATCH), .PWM_DRIVE(PWM_DRIVE), .OSC_KEEP(OSC_KEEP));

// [ers_src.sv]
/*
  External reset source model.
  Assumes selector 0 is in use; other candidates are noise.
*/
`timescale 1ns/10ps
module ers_src
(
  input  wire logic        CLK,
  input  wire logic        LVL,
  output logic      [15:0] RESET_SOURCES
);
  logic [14:0] noise_q; // Unselected candidates
  // Unselected lines advance by 15'h1235 every cycle
  always @(posedge CLK)
    noise_q <= noise_q + 15'h1235;
  assign RESET_SOURCES = {noise_q, LVL};
  initial noise_q = 15'h0000;
endmodule

// [hlt_timer_tb_top.sv]
/*
  Self-checking bench for the limit timer.
  Assumes the defs header and the ers_src model.
*/
`timescale 1ns/10ps
`include "hlt_timer_defs.svh"
module hlt_timer_tb_top;
  logic        CLK, RESET, WE_I, CYC_I, STB_I, SLEEP, lvl;
  logic        ACK_O, PERIOD_MATCH, PWM_DRIVE, OSC_KEEP;
  logic [5:0]  ADR_I;
  logic [3:0]  SEL_I;
  logic [31:0] DAT_I, DAT_O;
  logic [7:0]  COUNT_OUT, rd, per;
  logic        hi;
  logic [15:0] RESET_SOURCES;
  int          n_mismatch, n_tests, seed, m;
  initial
  begin
    CLK = 1'h0;
    forever #5 CLK = ~CLK;
  end
  hlt_timer i_dut (.CLK(CLK), .RESET(RESET), .ADR_I(ADR_I), .DAT_I(DAT_I), .DAT_O(DAT_O),
    .WE_I(WE_I), .SEL_I(SEL_I), .CYC_I(CYC_I), .STB_I(STB_I), .ACK_O(ACK_O),
    .RESET_SOURCES(RESET_SOURCES), .SLEEP(SLEEP), .COUNT_OUT(COUNT_OUT),
    .PERIOD_MATCH(PERIOD_MATCH), .PWM_DRIVE(PWM_DRIVE), .OSC_KEEP(OSC_KEEP));
  ers_src i_src (.CLK(CLK), .LVL(lvl), .RESET_SOURCES(RESET_SOURCES));
  ////////////////////////////////////////////////////////////////////////////
  // Level idle before a start edge, per mode
  function automatic logic pre(input int md);
    pre = 1'(8'h64 >> (md - 8));
  endfunction
  // Control read-back after a period match
  function automatic logic [7:0] ctl_after(input logic [7:0] w);
    ctl_after = w & 8'h7F;
  endfunction
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task give_verdict;
    if (n_mismatch == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // One classic bus cycle
  task wb(input logic [5:0] a, input logic w, input logic [7:0] d, input logic [3:0] s);
    int t;
    @(posedge CLK);
    ADR_I <= a;
    WE_I  <= w;
    DAT_I <= {24'h000000, d};
    SEL_I <= s;
    CYC_I <= 1'h1;
    STB_I <= 1'h1;
    t = 0;
    do
    begin
      @(posedge CLK);
      t++;
    end
    while (ACK_O !== 1'h1 && t < 50);
    if (t >= 50)
    begin
      n_mismatch++;
      give_verdict;
    end
    rd = DAT_O[7:0];
    CYC_I <= 1'h0;
    STB_I <= 1'h0;
  endtask
  task wr(input logic [5:0] a, input logic [7:0] d);
    wb(a, 1'h1, d, 4'hF);
  endtask
  task rchk(input logic [5:0] a, input logic [7:0] e, input string nm);
    wb(a, 1'h0, 8'h00, 4'hF);
    chk(nm, e, rd);
  endtask
  // Bounded wait for a period match
  task wait_match;
    int t;
    t = 0;
    hi = 1'h0;
    while (PERIOD_MATCH !== 1'h1 && t < 600)
    begin
      hi = hi | PWM_DRIVE;
      @(posedge CLK);
      t++;
    end
    chk("match", 8'h01, {7'h00, PERIOD_MATCH});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge CLK);
    n_mismatch++;
    give_verdict;
  end
  initial
  begin
    seed = 4;
    n_mismatch = 0;
    n_tests = 0;
    {RESET, WE_I, CYC_I, STB_I, SLEEP, lvl} = 6'h20;
    {ADR_I, SEL_I, DAT_I} = 42'h0;
    repeat (16) @(posedge CLK);
    RESET <= 1'h0;
    rchk(`OFS_PERIOD_VALUE, `RST_PERIOD, "period");
    rchk(`OFS_COUNT_VALUE, `RST_COUNT, "count");
    wb(`OFS_PERIOD_VALUE, 1'h1, 8'h33, 4'h0);
    rchk(`OFS_PERIOD_VALUE, `RST_PERIOD, "lane off");
    wr(6'h20, 8'h5A);
    rchk(6'h20, 8'h00, "unmapped");
    wr(`OFS_EXT_RESET_SELECT, 8'h00);
    // One-shot and start-edge modes with a random period
    for (m = 8; m < 16; m++)
    begin
      per = 8'h08 + {4'h0, 4'($random(seed))};
      lvl <= pre(m);
      wr(`OFS_TIMER_CONTROL, 8'h00);
      wr(`OFS_HW_LIMIT_CONTROL, m[7:0]);
      wr(`OFS_PERIOD_VALUE, per);
      wr(`OFS_PULSE_WIDTH, per >> 1);
      wr(`OFS_COUNT_VALUE, 8'h00);
      wr(`OFS_TIMER_CONTROL, 8'h80);
      if (m != 8)
      begin
        repeat (8) @(posedge CLK);
        chk("idle count", 8'h00, COUNT_OUT);
        lvl <= ~lvl;
      end
      wait_match;
      chk("drive seen", 8'h01, {7'h00, hi});
      chk("drive end", 8'h00, {7'h00, PWM_DRIVE});
      rchk(`OFS_TIMER_CONTROL, ctl_after(8'h80), "run");
      chk("stopped", 8'h00, COUNT_OUT);
    end
    // Limit one-shot: a later edge resets, counting resumes by itself
    lvl <= 1'h0;
    wr(`OFS_HW_LIMIT_CONTROL, {3'h0, `MODE_HL_OS_RISE});
    wr(`OFS_PERIOD_VALUE, 8'hF0);
    wr(`OFS_PULSE_WIDTH, 8'h08);
    wr(`OFS_TIMER_CONTROL, 8'h80);
    lvl <= 1'h1;
    repeat (20) @(posedge CLK);
    lvl <= 1'h0;
    repeat (8) @(posedge CLK);
    lvl <= 1'h1;
    repeat (12) @(posedge CLK);
    chk("limit reset", 8'h01, {7'h00, COUNT_OUT > 8'h00 && COUNT_OUT < 8'h08});
    chk("limit drive", 8'h01, {7'h00, PWM_DRIVE});
    // Edge one-shot halted by software waits for a fresh edge
    wr(`OFS_TIMER_CONTROL, 8'h00);
    lvl <= 1'h0;
    wr(`OFS_HW_LIMIT_CONTROL, {3'h0, `MODE_EDGE_OS_RISE});
    wr(`OFS_COUNT_VALUE, 8'h00);
    wr(`OFS_TIMER_CONTROL, 8'h80);
    lvl <= 1'h1;
    repeat (12) @(posedge CLK);
    wr(`OFS_TIMER_CONTROL, 8'h00);
    per = COUNT_OUT;
    wr(`OFS_TIMER_CONTROL, 8'h80);
    repeat (8) @(posedge CLK);
    chk("halted", per, COUNT_OUT);
    lvl <= 1'h0;
    repeat (8) @(posedge CLK);
    lvl <= 1'h1;
    repeat (12) @(posedge CLK);
    chk("resumed", 8'h01, {7'h00, COUNT_OUT > per});
    // Level limit mode
    lvl <= 1'h0;
    wr(`OFS_HW_LIMIT_CONTROL, {3'h0, `MODE_LVL_RST_LOW});
    wr(`OFS_PERIOD_VALUE, 8'h10);
    wr(`OFS_PULSE_WIDTH, 8'h04);
    wr(`OFS_TIMER_CONTROL, 8'h80);
    repeat (8) @(posedge CLK);
    chk("held", 8'h00, COUNT_OUT);
    lvl <= 1'h1;
    wait_match;
    repeat (3) @(posedge CLK);
    chk("match drive", 8'h01, {7'h00, PWM_DRIVE});
    wr(`OFS_TIMER_CONTROL, 8'h00);
    wr(`OFS_COUNT_VALUE, 8'h21);
    lvl <= 1'h0;
    repeat (8) @(posedge CLK);
    chk("ignored", 8'h21, COUNT_OUT);
    // Sleep with and without the sync bit
    wr(`OFS_HW_LIMIT_CONTROL, 8'h80 | `MODE_LVL_RST_HIGH);
    wr(`OFS_PERIOD_VALUE, 8'hFF);
    wr(`OFS_COUNT_VALUE, 8'h40);
    SLEEP <= 1'h1;
    wr(`OFS_TIMER_CONTROL, 8'h80);
    repeat (10) @(posedge CLK);
    chk("sleep hold", 8'h40, COUNT_OUT);
    wr(`OFS_HW_LIMIT_CONTROL, {3'h0, `MODE_LVL_RST_HIGH});
    wr(`OFS_TIMER_CLOCK_SELECT, 8'h01);
    wr(`OFS_COUNT_VALUE, 8'h40);
    repeat (10) @(posedge CLK);
    chk("osc keep", 8'h01, {7'h00, OSC_KEEP});
    chk("sleep run", 8'h01, {7'h00, COUNT_OUT > 8'h40});
    SLEEP <= 1'h0;
    give_verdict;
  end
endmodule
